// File: logic/rot_sub_halt_exec.sv
// Execution datapath for rotate, subtract, auxiliary moves and halt entry.
`timescale 1ns/10ps
`default_nettype none

module rot_sub_halt_exec
   import exec_pkg::*;
(
   // Clock and synchronous reset.
   input wire logic clock,
   input wire logic rst,
   // Decoded instruction from the decoder.
   input wire logic req_valid,
   input wire exec_req_t req,
   // Wake-up event from the wake logic.
   input wire logic wake,
   // Results and status towards the core.
   output logic op_done,
   output logic halted,
   output logic watchdog_clear,
   output logic [7:0] work_register,
   output flags_t flags,
   // AXI4-Lite write channels.
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   // Data registers and auxiliary page storage.
   logic [7:0] data_mem [64];
   logic [7:0] aux_page_register [16];

   // Execution state and its next values.
   run_state_t state, next_state;
   logic [7:0] next_work;
   flags_t next_flags;
   logic next_done, next_halted, next_wdclr;

   // Single write port of each storage array.
   logic mem_we, aux_we;
   logic [5:0] mem_waddr;
   logic [3:0] aux_waddr;
   logic [7:0] mem_wdata, aux_wdata;

   // Datapath intermediate values.
   logic op_fire;
   logic [7:0] src_byte, sub_opnd;
   logic [8:0] sub_sum;
   logic [4:0] low_sum;

   // Bus slave next values and decoded events.
   logic next_awready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_fire, ar_fire;
   region_t wr_region, rd_region;

   // Maps a bus byte address onto a register region.
   function automatic region_t decode(input logic [11:0] addr);
      region_t r;
      r = rg_none;
      if (addr[11:2] == ADDR_STATUS[11:2]) begin
         r = rg_status;
      end else if (addr[11:2] == ADDR_WORK[11:2]) begin
         r = rg_work;
      end else if (addr[11:2] == ADDR_FLAGS[11:2]) begin
         r = rg_flags;
      end else if (addr[11:8] == DATA_PAGE) begin
         r = rg_data;
      end else if (addr[11:6] == AUX_PAGE) begin
         r = rg_aux;
      end
      return r;
   endfunction

   // An instruction is taken only while the core runs.
   assign op_fire = req_valid && (state == st_run);
   assign src_byte = data_mem[req.reg_addr];
   assign sub_opnd = (req.op == imm_sub_borrow_op) ? req.imm : src_byte;
   // Subtraction is an addition of the inverted work register and carry.
   assign sub_sum = {1'b0, sub_opnd} + {1'b0, ~work_register}
      + {8'h00, flags.carry};
   assign low_sum = {1'b0, sub_opnd[3:0]} + {1'b0, ~work_register[3:0]}
      + {4'h0, flags.carry};

   // Next values of the datapath; bus writes first, instructions win.
   always_comb begin
      next_state = state;
      next_halted = halted;
      next_work = work_register;
      next_flags = flags;
      next_done = 1'b0;
      next_wdclr = 1'b0;
      mem_we = 1'b0;
      mem_waddr = awaddr[7:2];
      mem_wdata = wdata[7:0];
      aux_we = 1'b0;
      aux_waddr = awaddr[5:2];
      aux_wdata = wdata[7:0];
      // Software writes land when both write channels are taken.
      if (wr_fire && wstrb[0]) begin
         case (wr_region)
            rg_work: next_work = wdata[7:0];
            rg_flags: next_flags = flags_t'(wdata[4:0]);
            rg_data: mem_we = 1'b1;
            rg_aux: aux_we = 1'b1;
            default: next_work = work_register;
         endcase
      end
      // Instruction execution, one cycle each.
      if (op_fire) begin
         next_done = 1'b1;
         case (req.op)
            rot_right_carry_op: begin
               // Only carry changes; result chosen by destination.
               next_flags.carry = src_byte[0];
               if (req.dest_sel == DEST_WORK) begin
                  next_work = {flags.carry, src_byte[7:1]};
               end else begin
                  mem_we = 1'b1;
                  mem_waddr = req.reg_addr;
                  mem_wdata = {flags.carry, src_byte[7:1]};
               end
            end
            reg_sub_borrow_op, imm_sub_borrow_op: begin
               next_flags.carry = sub_sum[8];
               next_flags.half_carry_flag = low_sum[4];
               next_flags.zero = (sub_sum[7:0] == 8'h00);
               if (req.op == reg_sub_borrow_op
                   && req.dest_sel == DEST_REG) begin
                  mem_we = 1'b1;
                  mem_waddr = req.reg_addr;
                  mem_wdata = sub_sum[7:0];
               end else begin
                  next_work = sub_sum[7:0];
               end
            end
            aux_reg_write_op: begin
               // Work register goes into the selected page entry.
               aux_we = 1'b1;
               aux_waddr = req.aux_idx;
               aux_wdata = work_register;
            end
            aux_reg_read_op: begin
               // Page entry goes into the work register.
               next_work = aux_page_register[req.aux_idx];
            end
            halt_op: begin
               // Watchdog reset pulse and flag update, then halt.
               next_wdclr = 1'b1;
               next_flags.timeout_flag = 1'b1;
               next_flags.power_down_flag = 1'b0;
            end
            default: next_done = 1'b1;
         endcase
      end
      // Run and halt sequencing.
      case (state)
         st_run: begin
            if (op_fire && req.op == halt_op) begin
               next_state = st_halt;
               next_halted = 1'b1;
            end
         end
         st_halt: begin
            if (wake) begin
               next_state = st_run;
               next_halted = 1'b0;
            end
         end
         default: begin
            next_state = st_run;
            next_halted = 1'b0;
         end
      endcase
   end

   // Registers of the datapath.
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= st_run;
         halted <= 1'b0;
         work_register <= WORK_RESET;
         flags <= FLAGS_RESET;
         op_done <= 1'b0;
         watchdog_clear <= 1'b0;
      end else begin
         state <= next_state;
         halted <= next_halted;
         work_register <= next_work;
         flags <= next_flags;
         op_done <= next_done;
         watchdog_clear <= next_wdclr;
      end
   end

   // Storage arrays take their single write port; they have no reset.
   always_ff @(posedge clock) begin
      if (mem_we) begin
         data_mem[mem_waddr] <= mem_wdata;
      end
      if (aux_we) begin
         aux_page_register[aux_waddr] <= aux_wdata;
      end
   end

   // Bus slave handshakes.
   assign wr_fire = awvalid && wvalid && awready;
   assign ar_fire = arvalid && arready;
   assign wr_region = decode(awaddr);
   assign rd_region = decode(araddr);

   // Next values of the bus slave: one write and one read at a time.
   always_comb begin
      next_awready = 1'b0;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_arready = 1'b0;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      // Address and data are taken together once both are offered.
      if (awvalid && wvalid && !awready && !bvalid) begin
         next_awready = 1'b1;
      end
      if (wr_fire) begin
         next_bvalid = 1'b1;
         next_bresp = (wr_region == rg_none || wr_region == rg_status)
            ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (arvalid && !arready && !rvalid) begin
         next_arready = 1'b1;
      end
      if (ar_fire) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = 32'h0000_0000;
         case (rd_region)
            rg_status: begin
               next_rdata[7:0] = work_register;
               next_rdata[STAT_FLAGS_LSB +: 5] = flags;
               next_rdata[STAT_HALT_BIT] = halted;
            end
            rg_work: next_rdata[7:0] = work_register;
            rg_flags: next_rdata[4:0] = flags;
            rg_data: next_rdata[7:0] = data_mem[araddr[7:2]];
            rg_aux: next_rdata[7:0] = aux_page_register[araddr[5:2]];
            default: next_rresp = RESP_SLVERR;
         endcase
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
   end

   // Registers of the bus slave.
   always_ff @(posedge clock) begin
      if (rst) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0000_0000;
      end else begin
         awready <= next_awready;
         wready <= next_awready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   // Helper copies of the operands one cycle back, read only by checks.
   exec_req_t prev_req;
   logic [7:0] prev_src, prev_work;
   flags_t prev_flags;
   always_ff @(posedge clock) begin
      prev_req <= req;
      prev_src <= src_byte;
      prev_work <= work_register;
      prev_flags <= flags;
   end

   // Rotate result lands in its destination with the old carry on top.
   AST_ROT_VALUE: assert property (@(posedge clock) disable iff (rst)
      op_done && prev_req.op == rot_right_carry_op
      |-> flags.carry == prev_src[0]
          && ((prev_req.dest_sel == DEST_WORK)
              ? work_register == {prev_flags.carry, prev_src[7:1]}
              : data_mem[prev_req.reg_addr]
                == {prev_flags.carry, prev_src[7:1]}))
      else $error("rotate result or carry wrong");

   // Rotate leaves zero, digit carry and the halt flags alone.
   AST_ROT_FLAGS: assert property (@(posedge clock) disable iff (rst)
      op_fire && req.op == rot_right_carry_op
      |=> flags[4:1] == $past(flags[4:1]) && op_done)
      else $error("rotate touched a flag other than carry");

   // A write-back to a data register leaves the work register alone.
   AST_DEST_REG: assert property (@(posedge clock) disable iff (rst)
      op_fire && req.dest_sel == DEST_REG && !wr_fire
      && (req.op == rot_right_carry_op || req.op == reg_sub_borrow_op)
      |=> $stable(work_register))
      else $error("work register changed on write-back");

   // Register subtract produces the sum with borrow as carry.
   AST_SUB_REG: assert property (@(posedge clock) disable iff (rst)
      op_done && prev_req.op == reg_sub_borrow_op
      |-> {flags.carry, ((prev_req.dest_sel == DEST_WORK) ? work_register
           : data_mem[prev_req.reg_addr])}
          == {1'b0, prev_src} + {1'b0, ~prev_work}
          + {8'h00, prev_flags.carry})
      else $error("register subtract result wrong");

   // Immediate subtract always writes the work register.
   AST_SUB_IMM: assert property (@(posedge clock) disable iff (rst)
      op_done && prev_req.op == imm_sub_borrow_op
      |-> {flags.carry, work_register}
          == {1'b0, prev_req.imm} + {1'b0, ~prev_work}
          + {8'h00, prev_flags.carry})
      else $error("immediate subtract result wrong");

   // Digit carry and zero follow the subtraction.
   AST_SUB_FLAGS: assert property (@(posedge clock) disable iff (rst)
      op_done && (prev_req.op == imm_sub_borrow_op
                  || prev_req.op == reg_sub_borrow_op)
      |-> flags.half_carry_flag
          == (({1'b0, ((prev_req.op == imm_sub_borrow_op)
          ? prev_req.imm[3:0] : prev_src[3:0])} + {1'b0, ~prev_work[3:0]}
          + {4'h0, prev_flags.carry}) > 5'h0f)
          && flags.zero == ((prev_req.op == imm_sub_borrow_op
          || prev_req.dest_sel == DEST_WORK) ? work_register == 8'h00
          : data_mem[prev_req.reg_addr] == 8'h00))
      else $error("subtract digit carry or zero wrong");

   // Auxiliary write stores the work register and keeps the flags.
   AST_AUX_WR: assert property (@(posedge clock) disable iff (rst)
      op_done && prev_req.op == aux_reg_write_op
      |-> aux_page_register[prev_req.aux_idx] == prev_work
          && flags == prev_flags)
      else $error("auxiliary write wrong");

   // Auxiliary read loads the work register one cycle later.
   AST_AUX_RD: assert property (@(posedge clock) disable iff (rst)
      op_fire && req.op == aux_reg_read_op && !wr_fire
      |=> work_register == aux_page_register[$past(req.aux_idx)]
          && $stable(flags))
      else $error("auxiliary read wrong");

   // Halt entry pulses the watchdog clear for exactly one cycle.
   AST_WDT_CLR: assert property (@(posedge clock) disable iff (rst)
      op_fire && req.op == halt_op
      |=> watchdog_clear ##1 !watchdog_clear)
      else $error("watchdog clear pulse missing");

   // Halt entry updates the flags and halts the core.
   AST_HALT_FLAGS: assert property (@(posedge clock) disable iff (rst)
      op_fire && req.op == halt_op
      |=> flags.timeout_flag && !flags.power_down_flag && halted)
      else $error("halt entry flags wrong");

   // Nothing executes while halted and no wake arrives.
   AST_HALT_STALL: assert property (@(posedge clock) disable iff (rst)
      halted && !wake |=> !op_done && halted)
      else $error("instruction executed while halted");

endmodule

`default_nettype wire

// File: pkg/exec_pkg.sv
// Shared types and constants for the rotate, subtract and halt datapath.
`default_nettype none

package exec_pkg;

   // Operations that the decoder hands to this datapath.
   typedef enum logic [2:0] {
      rot_right_carry_op,
      reg_sub_borrow_op,
      imm_sub_borrow_op,
      aux_reg_write_op,
      aux_reg_read_op,
      halt_op,
      idle_op
   } exec_op_t;

   // One decoded instruction with all of its operand fields.
   typedef struct packed {
      exec_op_t op;
      logic [5:0] reg_addr;
      logic dest_sel;
      logic [7:0] imm;
      logic [3:0] aux_idx;
   } exec_req_t;

   // Status flags kept by the datapath.
   typedef struct packed {
      logic timeout_flag;
      logic power_down_flag;
      logic zero;
      logic half_carry_flag;
      logic carry;
   } flags_t;

   // Execution state: running or halted.
   typedef enum logic {st_run, st_halt} run_state_t;

   // Register regions seen from the bus.
   typedef enum logic [2:0] {
      rg_none, rg_status, rg_work, rg_flags, rg_data, rg_aux
   } region_t;

   // Destination select encodings.
   localparam logic DEST_WORK = 1'b0;
   localparam logic DEST_REG = 1'b1;

   // Bus byte offsets of the registers and page numbers of the data and auxiliary arrays.
   localparam logic [11:0] ADDR_STATUS = 12'h000;
   localparam logic [11:0] ADDR_WORK = 12'h004;
   localparam logic [11:0] ADDR_FLAGS = 12'h008;
   localparam logic [3:0] DATA_PAGE = 4'h1;
   localparam logic [5:0] AUX_PAGE = 6'h08;

   // Field positions inside the status word.
   localparam int STAT_FLAGS_LSB = 8;
   localparam int STAT_HALT_BIT = 16;

   // Values after reset.
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam flags_t FLAGS_RESET = 5'h18;

   // Bus response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// File: testbench/rot_sub_halt_exec_tb.sv
// Self-checking testbench for the rotate, subtract and halt datapath.
`timescale 1ns/10ps
`default_nettype none

module rot_sub_halt_exec_tb import exec_pkg::*;;

   // Clock, reset and instruction port.
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   exec_req_t req = '0;
   logic wake = 1'b0;
   logic op_done, halted, watchdog_clear;
   logic [7:0] work_register;
   flags_t flags;
   // Register bus master side.
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   // Check counters and the subtract reference.
   int error_cnt = 0;
   int n_compared = 0;
   logic [10:0] e;
   logic d;

   // Subtract operands and documented results.
   logic [7:0] tr [4] = '{8'h05, 8'h05, 8'h06, 8'h06};
   logic [7:0] tw [4] = '{8'h06, 8'h06, 8'h05, 8'h05};
   logic [7:0] tres [4] = '{8'hfe, 8'hff, 8'h00, 8'h01};

   // The 250 MHz clock.
   always #2 clock = ~clock;

   // Device under test.
   rot_sub_halt_exec rot_sub_halt_exec_i (.clock(clock), .rst(rst),
      .req_valid(req_valid), .req(req), .wake(wake), .op_done(op_done),
      .halted(halted), .watchdog_clear(watchdog_clear),
      .work_register(work_register), .flags(flags), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("compared %0d values, %0d wrong", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Counts one comparison and reports a mismatch.
   task automatic compare(input string name, input logic [31:0] exp,
         input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Ends the run when a handshake never completes.
   task automatic give_up(input string what);
      error_cnt++;
      $display("wait timed out for %s", what);
      tally_and_finish();
   endtask

   // One bus write with its response code checked.
   task automatic wr(input logic [11:0] a, input logic [31:0] dt,
         input logic [1:0] exp_resp);
      int i;
      @(posedge clock);
      awaddr <= a;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clock);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (bvalid !== 1'b1) give_up("write response");
      compare("bresp", 32'(exp_resp), 32'(bresp));
      bready <= 1'b0;
   endtask

   // One bus read with data and response code checked.
   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
         input logic [1:0] exp_resp);
      int i;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clock);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (rvalid !== 1'b1) give_up("read data");
      compare("rdata", exp, rdata);
      compare("rresp", 32'(exp_resp), 32'(rresp));
      rready <= 1'b0;
   endtask

   // Presents one instruction for one cycle and checks its completion.
   task automatic issue(input exec_op_t op, input logic [5:0] ra,
         input logic dd, input logic [7:0] im, input logic [3:0] ix,
         input logic exp_done);
      @(posedge clock);
      req_valid <= 1'b1;
      req <= '{op, ra, dd, im, ix};
      @(posedge clock);
      req_valid <= 1'b0;
      #1;
      compare("op_done", 32'(exp_done), 32'(op_done));
   endtask

   // Expected subtract result and {zero, half carry, carry}.
   function automatic logic [10:0] sbc_ref(input logic [7:0] a,
         input logic [7:0] w, input logic c);
      logic [8:0] s;
      logic [4:0] lo;
      s = {1'b0, a} + {1'b0, ~w} + 9'(c);
      lo = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'(c);
      return {s[7:0], s[7:0] == 8'h00, lo[4], s[8]};
   endfunction

   // Main sequence.
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rd(ADDR_STATUS, 32'h00001800, RESP_OKAY);
      rd(12'hffc, 32'h0, RESP_SLVERR);
      wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
      $display("test reset_and_map done");
      // Rotate into data register 63, then into the work register.
      wr(12'h1fc, 32'ha5, RESP_OKAY);
      wr(ADDR_WORK, 32'h33, RESP_OKAY);
      wr(ADDR_FLAGS, 32'h1e, RESP_OKAY);
      issue(rot_right_carry_op, 6'h3f, DEST_REG, 8'h0, 4'h0, 1'b1);
      rd(12'h1fc, 32'h52, RESP_OKAY);
      compare("work", 32'h33, 32'(work_register));
      compare("flags", 32'h1f, 32'(flags));
      issue(rot_right_carry_op, 6'h3f, DEST_WORK, 8'h0, 4'h0, 1'b1);
      compare("work", 32'ha9, 32'(work_register));
      compare("flags", 32'h1e, 32'(flags));
      $display("test rotate done");
      // Both subtract forms over the documented operand table.
      for (int k = 0; k < 4; k++) begin
         d = k[1] ^ k[0];
         e = sbc_ref(tr[k], tw[k], k[0]);
         wr(ADDR_WORK, 32'(tw[k]), RESP_OKAY);
         wr(ADDR_FLAGS, 32'h18 | k[0], RESP_OKAY);
         wr(12'h124, 32'(tr[k]), RESP_OKAY);
         issue(reg_sub_borrow_op, 6'h09, d, 8'h0, 4'h0, 1'b1);
         compare("flags", 32'({2'b11, e[2:0]}), 32'(flags));
         if (d) begin
            rd(12'h124, 32'(tres[k]), RESP_OKAY);
            compare("work", 32'(tw[k]), 32'(work_register));
         end else begin
            compare("work", 32'(tres[k]), 32'(work_register));
         end
         wr(ADDR_WORK, 32'(tw[k]), RESP_OKAY);
         wr(ADDR_FLAGS, 32'h18 | k[0], RESP_OKAY);
         issue(imm_sub_borrow_op, 6'h00, 1'b0, tr[k], 4'h0, 1'b1);
         compare("work", 32'(tres[k]), 32'(work_register));
         compare("flags", 32'({2'b11, e[2:0]}), 32'(flags));
      end
      $display("test subtract done");
      // Auxiliary page moves at both ends of the index range.
      wr(ADDR_WORK, 32'h3c, RESP_OKAY);
      wr(ADDR_FLAGS, 32'h0d, RESP_OKAY);
      issue(aux_reg_write_op, 6'h00, 1'b0, 8'h0, 4'hf, 1'b1);
      compare("flags", 32'h0d, 32'(flags));
      rd(12'h23c, 32'h3c, RESP_OKAY);
      wr(ADDR_WORK, 32'hc3, RESP_OKAY);
      issue(aux_reg_write_op, 6'h00, 1'b0, 8'h0, 4'h0, 1'b1);
      rd(12'h200, 32'hc3, RESP_OKAY);
      wr(ADDR_WORK, 32'h00, RESP_OKAY);
      issue(aux_reg_read_op, 6'h00, 1'b0, 8'h0, 4'hf, 1'b1);
      compare("work", 32'h3c, 32'(work_register));
      compare("flags", 32'h0d, 32'(flags));
      rd(12'h23c, 32'h3c, RESP_OKAY);
      $display("test aux_page done");
      // Halt entry, an ignored request while halted, then wake-up.
      wr(ADDR_FLAGS, 32'h0b, RESP_OKAY);
      issue(halt_op, 6'h00, 1'b0, 8'h0, 4'h0, 1'b1);
      compare("watchdog_clear", 32'h1, 32'(watchdog_clear));
      compare("halted", 32'h1, 32'(halted));
      compare("flags", 32'h13, 32'(flags));
      @(posedge clock);
      #1;
      compare("watchdog_clear", 32'h0, 32'(watchdog_clear));
      issue(aux_reg_read_op, 6'h00, 1'b0, 8'h0, 4'h0, 1'b0);
      compare("work", 32'h3c, 32'(work_register));
      @(posedge clock);
      wake <= 1'b1;
      @(posedge clock);
      wake <= 1'b0;
      #1;
      compare("halted", 32'h0, 32'(halted));
      rd(ADDR_STATUS, 32'h0000133c, RESP_OKAY);
      issue(aux_reg_read_op, 6'h00, 1'b0, 8'h0, 4'h0, 1'b1);
      compare("work", 32'hc3, 32'(work_register));
      $display("test halt done");
      tally_and_finish();
   end

endmodule

`default_nettype wire
